// ### src/pcr_phase_delay.sv
// Tapped delay line that offsets the frequency output by 0 to 7 clocks.
// Assumes the source is sampled on core_clk, which acts as the oscillator-PLL clock.
`timescale 1ns/1ns
module pcr_phase_delay
  import pcr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       src,
  input  wire logic [2:0] delay_sel,
  output logic            dly_out
);

  logic [7:1] tap_r;
  logic [7:0] taps;

  // Shift history of the selected clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_r <= 7'h00;
    end else begin
      tap_r <= {tap_r[6:1], src};
    end
  end

  // Tap zero is the live source, so a zero setting adds no delay
  assign taps    = {tap_r, src};
  assign dly_out = taps[delay_sel];

endmodule

// ### src/pcr_pkg.sv
// Constants for the clock configuration and interrupt mask register bank.
// Assumes a 100 MHz core clock that also stands in for the oscillator-PLL clock.
package pcr_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets (word index on the register port)
  localparam logic [3:0] OFF_CLK_CFG1 = 4'h0;
  localparam logic [3:0] OFF_CLK_CFG2 = 4'h1;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h2;
  localparam logic [3:0] OFF_IRQ_FLAG = 4'h3;

  // Reset values
  localparam logic [15:0] CLK_CFG1_RST = 16'h0000;
  localparam logic [15:0] CLK_CFG2_RST = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
  localparam logic [15:0] IRQ_FLAG_RST = 16'h0000;

  // Writable and readable bit sets; data bit 0 is register bit 8
  localparam logic [15:0] CLK_CFG1_WMASK = 16'hffff;
  localparam logic [15:0] CLK_CFG1_RMASK = 16'hffbf;
  localparam logic [15:0] CLK_CFG2_MASK  = 16'h0003;
  localparam logic [15:0] IRQ_MASK_MASK  = 16'hbfff;

  // Field positions in clock_config_one
  localparam int CLK_INT_FREQ_LSB = 0;
  localparam int SPREAD_EN_BIT    = 4;
  localparam int FIN_DIV_BIT      = 5;
  localparam int EXT_FIN_BIT      = 6;
  localparam int FOUT_PICK_BIT    = 7;
  localparam int FOUT_DELAY_LSB   = 8;
  localparam int FOUT_SRC_LSB     = 11;
  localparam int SPREAD_PROF_BIT  = 15;

  // Field positions in clock_config_two and in the mask and flag layout
  localparam int LP_CLK_LSB     = 0;
  localparam int THERM_LSB      = 0;
  localparam int OC_LSB         = 8;
  localparam int OC_RESERVED    = 14;

  // Timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int SPREAD_SLOW_HZ = 23150;
  localparam int SPREAD_FAST_HZ = 92600;
  localparam int SPREAD_STEPS   = 200;
  localparam int SPREAD_LIMIT   = 50;
  localparam logic [7:0] STEP_SLOW = 8'(CLK_HZ / (SPREAD_SLOW_HZ * SPREAD_STEPS));
  localparam logic [7:0] STEP_FAST = 8'(CLK_HZ / (SPREAD_FAST_HZ * SPREAD_STEPS));
  localparam int LP_100K_HZ = 100_000;
  localparam int LP_300K_HZ = 300_000;
  localparam int LP_600K_HZ = 600_000;
  localparam logic [9:0] LP_HALF_100K = 10'(CLK_HZ / (2 * LP_100K_HZ));
  localparam logic [9:0] LP_HALF_300K = 10'(CLK_HZ / (2 * LP_300K_HZ));
  localparam logic [9:0] LP_HALF_600K = 10'(CLK_HZ / (2 * LP_600K_HZ));

  // Spread triangle direction
  typedef enum logic [1:0] {
    PCR_SPR_UP = 2'b01,
    PCR_SPR_DN = 2'b10
  } pcr_spr_dir_t;

endpackage

// ### src/pcr_regs.sv
// Clock configuration and first interrupt mask register bank of a power-management device.
// Assumes a single 100 MHz clock, a plain strobe register port and rail events as one-cycle pulses.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns

// What this block does
// - Nonzero phase field delays frequency output by that many PLL clocks.
// - Phase field zero means no delay; it resets to zero.
// - Output pick bit 0 selects first clock, 1 selects second clock.
// - Profile bit 0 gives plus/minus five percent spread at 23.15 kHz; steps of 21 core clocks give about 23.8 kHz.
// - Profile bit 1 gives plus/minus five percent spread at 92.6 kHz; steps of 5 core clocks give 100 kHz.
// - Reset clears the profile bit, so the slower profile applies.
// - Low-power clock 100 kHz for 00/01, 300 kHz for 10, 600 kHz for 11.
// - Thermal mask bit 1 blocks that rail's thermal interrupt; 0 passes it.
// - Thermal masks sit at bits 15..8 in the given rail order.
// - Overcurrent mask bit 1 blocks that rail's interrupt; 0 passes it.
// - Overcurrent masks at bits 23..16, bit 22 reserved.
// - Reset clears every mask bit so all events can interrupt.
module pcr_regs
  import pcr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              clk1_in,
  input  wire logic              clk2_in,
  input  wire logic [15:0]       rail_evt,
  output logic                   freq_out,
  output logic      [3:0]        freq_out_source_sel,
  output logic      [3:0]        clk_int_freq,
  output logic                   fin_div,
  output logic                   ext_fin_sel,
  output logic                   spread_enable,
  output logic                   spread_profile_sel,
  output logic      [6:0]        spread_offset,
  output logic                   lp_clk_out,
  output logic      [1:0]        lp_clk_sel,
  output logic                   irq
);

  // Address match for one register, shared by read and write decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    addr_hit = (a == off);
  endfunction

  // Half period of the low-power clock in core clocks
  function automatic logic [9:0] lp_half(input logic [1:0] code);
    case (code)
      2'b10:   lp_half = LP_HALF_300K;
      2'b11:   lp_half = LP_HALF_600K;
      default: lp_half = LP_HALF_100K;
    endcase
  endfunction

  logic [15:0]  cfg1_r;
  logic [15:0]  cfg2_r;
  logic [15:0]  mask_r;
  logic [15:0]  flag_r;
  logic [15:0]  flag_nxt;
  logic [15:0]  rdata_r;
  logic [15:0]  rd_mux;
  logic         wr_cfg1;
  logic         wr_cfg2;
  logic         wr_mask;
  logic         wr_flag;
  logic [2:0]   freq_out_delay_sel;
  logic         freq_out_clock_pick;
  logic         pick_src;
  logic [7:0]   step_len;
  logic [7:0]   step_cnt_r;
  logic         spread_tick;
  logic [6:0]   spr_off_r;
  pcr_spr_dir_t spr_dir_r;
  logic [9:0]   lp_cnt_r;
  logic         lp_toggle;
  logic         lp_clk_r;

  // Write decode
  assign wr_cfg1 = reg_wr && addr_hit(reg_addr, OFF_CLK_CFG1);
  assign wr_cfg2 = reg_wr && addr_hit(reg_addr, OFF_CLK_CFG2);
  assign wr_mask = reg_wr && addr_hit(reg_addr, OFF_IRQ_MASK);
  assign wr_flag = reg_wr && addr_hit(reg_addr, OFF_IRQ_FLAG);

  // Configuration registers; reserved bits are dropped on write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_r <= CLK_CFG1_RST;
      cfg2_r <= CLK_CFG2_RST;
      mask_r <= IRQ_MASK_RST;
    end else begin
      if (wr_cfg1) begin
        cfg1_r <= reg_wdata & CLK_CFG1_WMASK;
      end
      if (wr_cfg2) begin
        cfg2_r <= reg_wdata & CLK_CFG2_MASK;
      end
      if (wr_mask) begin
        mask_r <= reg_wdata & IRQ_MASK_MASK;
      end
    end
  end

  // Sticky rail flags: a new event wins over a write-one-to-clear in the same cycle
  assign flag_nxt = (flag_r & ~(wr_flag ? reg_wdata : 16'h0000)) | (rail_evt & IRQ_MASK_MASK);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= IRQ_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // One level interrupt from every unmasked flag
  assign irq = |(flag_r & ~mask_r);

  // Read selection; unmapped offsets read as zero
  assign rd_mux = addr_hit(reg_addr, OFF_CLK_CFG1) ? (cfg1_r & CLK_CFG1_RMASK) :
                  addr_hit(reg_addr, OFF_CLK_CFG2) ? cfg2_r :
                  addr_hit(reg_addr, OFF_IRQ_MASK) ? mask_r :
                  addr_hit(reg_addr, OFF_IRQ_FLAG) ? flag_r : 16'h0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;

  // Field breakout
  assign freq_out_delay_sel  = cfg1_r[FOUT_DELAY_LSB +: 3];
  assign freq_out_clock_pick = cfg1_r[FOUT_PICK_BIT];
  assign freq_out_source_sel = cfg1_r[FOUT_SRC_LSB +: 4];
  assign clk_int_freq        = cfg1_r[CLK_INT_FREQ_LSB +: 4];
  assign fin_div             = cfg1_r[FIN_DIV_BIT];
  assign ext_fin_sel         = cfg1_r[EXT_FIN_BIT];
  assign spread_enable       = cfg1_r[SPREAD_EN_BIT];
  assign spread_profile_sel  = cfg1_r[SPREAD_PROF_BIT];
  assign lp_clk_sel          = cfg2_r[LP_CLK_LSB +: 2];

  // Output clock choice ahead of the delay line
  assign pick_src = freq_out_clock_pick ? clk2_in : clk1_in;

  // Delay of 0..7 core clocks; zero is a straight path
  pcr_phase_delay u_delay (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .src       (pick_src),
    .delay_sel (freq_out_delay_sel),
    .dly_out   (freq_out)
  );

  // Spread step pacing; a profile change restarts the step so the rate never glitches short
  assign step_len    = spread_profile_sel ? STEP_FAST : STEP_SLOW;
  assign spread_tick = spread_enable && (step_cnt_r == step_len - 8'h01);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_r <= 8'h00;
    end else if (!spread_enable || wr_cfg1 || spread_tick) begin
      step_cnt_r <= 8'h00;
    end else begin
      step_cnt_r <= step_cnt_r + 8'h01;
    end
  end

  // Triangle of the offset in tenths of a percent, bounded to the five percent range
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      spr_off_r <= 7'h00;
      spr_dir_r <= PCR_SPR_UP;
    end else if (!spread_enable) begin
      spr_off_r <= 7'h00;
      spr_dir_r <= PCR_SPR_UP;
    end else if (spread_tick) begin
      case (spr_dir_r)
        PCR_SPR_UP: begin
          if ($signed(spr_off_r) == 7'(SPREAD_LIMIT)) begin
            spr_dir_r <= PCR_SPR_DN;
            spr_off_r <= spr_off_r - 7'h01;
          end else begin
            spr_off_r <= spr_off_r + 7'h01;
          end
        end
        PCR_SPR_DN: begin
          if ($signed(spr_off_r) == -7'(SPREAD_LIMIT)) begin
            spr_dir_r <= PCR_SPR_UP;
            spr_off_r <= spr_off_r + 7'h01;
          end else begin
            spr_off_r <= spr_off_r - 7'h01;
          end
        end
        default: begin
          spr_dir_r <= PCR_SPR_UP;
          spr_off_r <= 7'h00;
        end
      endcase
    end
  end

  assign spread_offset = spr_off_r;

  // Low-power clock divider; a new code takes effect at once
  assign lp_toggle = (lp_cnt_r == lp_half(lp_clk_sel) - 10'h001);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_cnt_r <= 10'h000;
      lp_clk_r <= 1'b0;
    end else if (wr_cfg2 || lp_toggle) begin
      lp_cnt_r <= 10'h000;
      lp_clk_r <= lp_toggle ? ~lp_clk_r : lp_clk_r;
    end else begin
      lp_cnt_r <= lp_cnt_r + 10'h001;
    end
  end

  assign lp_clk_out = lp_clk_r;

  // Helper counters that only the checks read
  logic [3:0] phase_age_r;
  logic [7:0] spr_gap_r;
  logic [9:0] lp_gap_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_age_r <= 4'h0;
      spr_gap_r   <= 8'h01;
      lp_gap_r    <= 10'h001;
    end else begin
      phase_age_r <= wr_cfg1 ? 4'h0 : ((phase_age_r == 4'hf) ? phase_age_r : phase_age_r + 4'h1);
      spr_gap_r   <= (!spread_enable || wr_cfg1 || spread_tick) ? 8'h01 : spr_gap_r + 8'h01;
      lp_gap_r    <= (wr_cfg2 || lp_toggle) ? 10'h001 : lp_gap_r + 10'h001;
    end
  end

  sequence s_phase_settled;
    (freq_out_delay_sel == 3'h7) && (phase_age_r >= 4'h8);
  endsequence

  property p_phase_delay;
    @(posedge core_clk) disable iff (!rst_n)
      s_phase_settled |-> (freq_out == $past(pick_src, 7));
  endproperty
  a_phase_delay: assert property (p_phase_delay) else $error("freq out not seven clocks late");

  property p_phase_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (freq_out_delay_sel == 3'h0) |-> (freq_out == (freq_out_clock_pick ? clk2_in : clk1_in));
  endproperty
  a_phase_zero: assert property (p_phase_zero) else $error("freq out delayed at zero phase");

  property p_pick_second;
    @(posedge core_clk) disable iff (!rst_n)
      (freq_out_delay_sel == 3'h0 && cfg1_r[FOUT_PICK_BIT]) |-> (freq_out == clk2_in);
  endproperty
  a_pick_second: assert property (p_pick_second) else $error("second clock not routed");

  sequence s_slow_step;
    spread_tick && !spread_profile_sel;
  endsequence

  property p_slow_rate;
    @(posedge core_clk) disable iff (!rst_n)
      s_slow_step |-> (spr_gap_r == STEP_SLOW);
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow spread step spacing wrong");

  property p_fast_rate;
    @(posedge core_clk) disable iff (!rst_n)
      (spread_tick && spread_profile_sel) |-> (spr_gap_r == STEP_FAST);
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("fast spread step spacing wrong");

  property p_spread_range;
    @(posedge core_clk) disable iff (!rst_n)
      spread_enable |=> ($signed(spread_offset) <= 7'sd50 && $signed(spread_offset) >= -7'sd50);
  endproperty
  a_spread_range: assert property (p_spread_range) else $error("spread offset out of range");

  property p_reset_clear;
    @(posedge core_clk) disable iff (!rst_n)
      !$past(rst_n) |-> (!spread_profile_sel && mask_r == 16'h0000 && lp_clk_sel == 2'b00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset values wrong");

  property p_lp_rate;
    @(posedge core_clk) disable iff (!rst_n)
      lp_toggle |=> (lp_clk_out != $past(lp_clk_out)) && ($past(lp_gap_r) == $past(lp_half(lp_clk_sel)));
  endproperty
  a_lp_rate: assert property (p_lp_rate) else $error("low-power clock half period wrong");

  property p_unmasked_irq;
    @(posedge core_clk) disable iff (!rst_n)
      (rail_evt[OC_LSB] && !mask_r[OC_LSB] && !wr_mask) |=> irq;
  endproperty
  a_unmasked_irq: assert property (p_unmasked_irq) else $error("unmasked event gave no interrupt");

  property p_masked_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      (mask_r == IRQ_MASK_MASK) |-> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked events raised interrupt");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && addr_hit(reg_addr, OFF_IRQ_MASK)) |=> (reg_rdata[OC_RESERVED] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mask bit read as one");

  property p_set_wins;
    @(posedge core_clk) disable iff (!rst_n)
      (rail_evt[THERM_LSB] && wr_flag && reg_wdata[THERM_LSB]) |=> flag_r[THERM_LSB];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

endmodule

// ### tb/tb.sv
// Self-checking bench for the clock configuration and interrupt mask register bank.
// Assumes pcr_pkg and pcr_regs are compiled first; one 100 MHz clock drives everything.
`timescale 1ns/1ns
module tb
  import pcr_pkg::*;
;
  logic              core_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              clk1_in = 1'b0;
  logic              clk2_in = 1'b0;
  logic [15:0]       rail_evt;
  logic              freq_out;
  logic [3:0]        freq_out_source_sel;
  logic [3:0]        clk_int_freq;
  logic              fin_div;
  logic              ext_fin_sel;
  logic              spread_enable;
  logic              spread_profile_sel;
  logic [6:0]        spread_offset;
  logic              lp_clk_out;
  logic [1:0]        lp_clk_sel;
  logic              irq;
  logic [7:0]        h1 = 8'h00;
  logic [7:0]        h2 = 8'h00;
  int                cyc = 0;
  int                mismatches;
  int                samples_checked;
  int                i;

  pcr_regs dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk1_in(clk1_in),
    .clk2_in(clk2_in), .rail_evt(rail_evt), .freq_out(freq_out),
    .freq_out_source_sel(freq_out_source_sel), .clk_int_freq(clk_int_freq), .fin_div(fin_div),
    .ext_fin_sel(ext_fin_sel), .spread_enable(spread_enable), .spread_profile_sel(spread_profile_sel),
    .spread_offset(spread_offset), .lp_clk_out(lp_clk_out), .lp_clk_sel(lp_clk_sel), .irq(irq)
  );

  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Irregular patterns on both internal clocks, so a wrong tap cannot match by luck
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    clk1_in <= cyc[1] ^ cyc[3] ^ cyc[4];
    clk2_in <= cyc[0] ^ cyc[2] ^ cyc[5];
  end

  // Source history, newest in bit 0, taken mid-cycle where inputs are settled
  always @(negedge core_clk) begin
    h1 <= {h1[6:0], clk1_in};
    h2 <= {h2[6:0], clk2_in};
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Step off the edge so callers see the register that this edge loaded
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic phase_run(input logic pick, input logic [2:0] dly);
    logic [7:0] v;
    wr(OFF_CLK_CFG1, {5'h00, dly, pick, 7'h00});
    repeat (10) @(negedge core_clk);
    repeat (16) begin
      @(negedge core_clk);
      v = pick ? {h2[6:0], clk2_in} : {h1[6:0], clk1_in};
      chk("freq_out", freq_out, v[dly]);
    end
  endtask

  task automatic spread_run(input logic prof, input int exp_step);
    int         n;
    int         mx;
    int         mn;
    logic [6:0] last;
    wr(OFF_CLK_CFG1, {prof, 10'h000, 1'b1, 4'h0});
    chk("spread_profile_sel", spread_profile_sel, prof);
    last = spread_offset;
    for (n = 0; n < 100 && spread_offset === last; n++) begin
      @(posedge core_clk);
      #1;
    end
    last = spread_offset;
    for (n = 0; n < 100 && spread_offset === last; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("spread step", n, exp_step);
    mx = 0;
    mn = 0;
    // A bit more than one whole triangle of 200 steps
    repeat (210 * exp_step) begin
      @(posedge core_clk);
      #1;
      if ($signed(spread_offset) > mx) mx = $signed(spread_offset);
      if ($signed(spread_offset) < mn) mn = $signed(spread_offset);
    end
    chk("spread top", mx, 50);
    chk("spread bottom", mn, -50);
  endtask

  task automatic lp_run(input logic [1:0] code, input int exp_half);
    int   n;
    logic last;
    wr(OFF_CLK_CFG2, {14'h0000, code});
    chk("lp_clk_sel", lp_clk_sel, code);
    last = lp_clk_out;
    for (n = 0; n < 1200 && lp_clk_out === last; n++) begin
      @(posedge core_clk);
      #1;
    end
    last = lp_clk_out;
    for (n = 0; n < 1200 && lp_clk_out === last; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("lp half period", n, exp_half);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 9k cycles, this allows a little over three times that
  initial begin
    #300_000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic [15:0] evt;
    rst_n           = 1'b0;
    reg_addr        = '0;
    reg_wdata       = '0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    rail_evt        = '0;
    mismatches      = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset state of every register, then idle read data, spread offset and interrupt
    rd_chk("clock_config_one", OFF_CLK_CFG1, 16'h0000);
    rd_chk("clock_config_two", OFF_CLK_CFG2, 16'h0000);
    rd_chk("irq_mask", OFF_IRQ_MASK, 16'h0000);
    rd_chk("irq_flag", OFF_IRQ_FLAG, 16'h0000);
    @(posedge core_clk);
    #1;
    chk("rdata after read", reg_rdata, 16'h0000);
    chk("spread_offset idle", spread_offset, 7'h00);
    chk("irq idle", irq, 1'b0);
    // All ones: reserved places must read zero
    wr(OFF_CLK_CFG1, 16'hffff);
    chk("cfg1 outputs", {freq_out_source_sel, clk_int_freq, fin_div, ext_fin_sel, spread_enable,
        spread_profile_sel}, 12'hfff);
    rd_chk("clock_config_one", OFF_CLK_CFG1, 16'hffbf);
    wr(OFF_CLK_CFG2, 16'hffff);
    rd_chk("clock_config_two", OFF_CLK_CFG2, 16'h0003);
    wr(OFF_IRQ_MASK, 16'hffff);
    rd_chk("irq_mask", OFF_IRQ_MASK, 16'hbfff);
    wr(4'h7, 16'hffff);
    rd_chk("unmapped", 4'h7, 16'h0000);
    // Every delay on both sources
    for (i = 0; i < 16; i++) begin
      phase_run(i[3], i[2:0]);
    end
    spread_run(1'b0, 100_000_000 / (23150 * 200));
    spread_run(1'b1, 100_000_000 / (92600 * 200));
    lp_run(2'b00, 100_000_000 / (2 * 100_000));
    lp_run(2'b01, 100_000_000 / (2 * 100_000));
    lp_run(2'b10, 100_000_000 / (2 * 300_000));
    lp_run(2'b11, 100_000_000 / (2 * 600_000));
    // Each rail event alone: pass, mask own bit, mask all others, clear
    for (i = 0; i < 16; i++) begin
      evt = 16'h0001 << i;
      wr(OFF_IRQ_MASK, 16'h0000);
      @(posedge core_clk);
      rail_evt <= evt;
      @(posedge core_clk);
      rail_evt <= 16'h0000;
      #1;
      chk("irq on event", irq, i != 14);
      rd_chk("irq_flag", OFF_IRQ_FLAG, (i == 14) ? 16'h0000 : evt);
      wr(OFF_IRQ_MASK, evt);
      #1;
      chk("irq own masked", irq, 1'b0);
      wr(OFF_IRQ_MASK, ~evt);
      #1;
      chk("irq others masked", irq, i != 14);
      wr(OFF_IRQ_FLAG, evt);
      #1;
      chk("irq cleared", irq, 1'b0);
    end
    // An event in the same cycle as its own clear keeps the flag set
    wr(OFF_IRQ_MASK, 16'h0000);
    @(posedge core_clk);
    rail_evt  <= 16'h0001;
    reg_wr    <= 1'b1;
    reg_addr  <= OFF_IRQ_FLAG;
    reg_wdata <= 16'h0001;
    @(posedge core_clk);
    rail_evt <= 16'h0000;
    reg_wr   <= 1'b0;
    #1;
    chk("irq set over clear", irq, 1'b1);
    rd_chk("irq_flag", OFF_IRQ_FLAG, 16'h0001);
    // Second reset in mid-run brings the slow profile and zero masks back
    wr(OFF_CLK_CFG1, 16'h8000);
    wr(OFF_IRQ_MASK, 16'h00ff);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("profile after reset", spread_profile_sel, 1'b0);
    rd_chk("clock_config_one", OFF_CLK_CFG1, 16'h0000);
    rd_chk("irq_mask", OFF_IRQ_MASK, 16'h0000);
    tally_and_finish();
  end
endmodule
